/* inc/slag_map.vh */
// Constants for the stack limit and address generation block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef SLAG_MAP_VH
`define SLAG_MAP_VH

// -----------------------------------------------------------------
// Register and width figures
// -----------------------------------------------------------------
`define SLAG_SP_INDEX 4'hf
`define SLAG_DEFAULT_WORKING_REGISTER_INDEX 4'h0
`define SLAG_STACK_FLOOR 16'h0800
`define SLAG_WORD_STEP 16'h0002
`define SLAG_NEAR_WIDTH 13
`define SLAG_LIT5_WIDTH 5'd5
`define SLAG_LIT10_WIDTH 5'd10
`define SLAG_LIT8_WIDTH 5'd8
`define SLAG_LIT16_WIDTH 5'd16
`define SLAG_BRA_WIDTH 5'd16
`define SLAG_DISABLE_INTERRUPTS_INSTR_WIDTH 5'd14

// -----------------------------------------------------------------
// Addressing modes (one-hot)
// -----------------------------------------------------------------
`define SLAG_MODE_FILE 8'h01
`define SLAG_MODE_DIRECT 8'h02
`define SLAG_MODE_INDIRECT 8'h04
`define SLAG_MODE_POST 8'h08
`define SLAG_MODE_PRE 8'h10
`define SLAG_MODE_INDEXED 8'h20
`define SLAG_MODE_LITOFF 8'h40
`define SLAG_MODE_LITERAL 8'h80

// -----------------------------------------------------------------
// Stack operations (one-hot)
// -----------------------------------------------------------------
`define SLAG_STK_NONE 4'h1
`define SLAG_STK_PUSH 4'h2
`define SLAG_STK_POP 4'h4
`define SLAG_STK_PCPUSH 4'h8

`endif

/* rtl/slag_limit_check.v */
// Stack limit comparator: checks an effective address against limit and floor.
// Assumes the caller qualifies the result with a stack-pointer use.
`timescale 1ns/1ps
`default_nettype none
`include "slag_map.vh"

module slag_limit_check
#(
    parameter AW = 16
)
(
    input wire [AW-1:0] addr_i,
    input wire [AW-1:0] limit_i,
    input wire check_i,
    output wire over_o,
    output wire under_o
);

    // Above limit traps; equal does not
    assign over_o = check_i && (addr_i > limit_i);
    // Below floor protects the special register space
    assign under_o = check_i && (addr_i < `SLAG_STACK_FLOOR);

endmodule
`default_nettype wire

/* rtl/slag_core.v */
// Data address generation and software stack checking for a 16-bit core.
// Assumes decoder drives one request per cycle with the register file
// values already read; data memory takes ea_o in the same cycle.
// How it works
// - Working register fifteen doubles as the software stack pointer.
// - Pointer addresses first free word; stack grows upward.
// - Pop decrements before access; push increments after access.
// - Call pushes program counter high part zero-extended.
// - Exception push joins status low byte with program counter high part.
// - Stack limit register has no reset value.
// - Stack limit bit zero always reads zero.
// - Every address formed through the stack pointer is checked against limit, except when mode is file, direct or literal.
// - Push at limit is fine; the next push traps.
// - Stack pointer address below 0x0800 raises underflow trap.
// - File register address is thirteen bits, near data space.
// - File register ops use register zero as default working register.
// - Operand one register direct; operand two register, memory or literal.
// - Three-operand literals come in five and ten bit widths.
// - Post-modified: pointer gives address, then steps by constant.
// - Pre-modified: pointer steps by signed constant, result is address.
// - Indexed: address is pointer plus base operand register.
// - Literal offset: address is pointer plus instruction literal.
// - Move shares one four-bit offset field for both ends.
// - Move adds indexed and literal-offset modes, eight and sixteen bit literals.
// - Branch takes signed sixteen-bit literal; interrupt disable unsigned fourteen.
`timescale 1ns/1ps
`default_nettype none
`include "slag_map.vh"

module slag_core
#(
    parameter AW = 16
)
(
    input wire clock_i,
    input wire rst_n_i,
    input wire req_i,
    input wire [7:0] mode_i,
    input wire [3:0] ptr_sel_i,
    input wire [AW-1:0] ptr_val_i,
    input wire [AW-1:0] base_val_i,
    input wire [3:0] offset_sel_i,
    input wire [AW-1:0] literal_i,
    input wire [1:0] lit_width_i,
    input wire step_down_i,
    input wire [AW-1:0] step_i,
    input wire [12:0] file_addr_i,
    input wire [3:0] stack_op_i,
    input wire exception_i,
    input wire [7:0] status_low_i,
    input wire [6:0] pc_high_i,
    input wire limit_wr_i,
    input wire [AW-1:0] limit_data_i,
    output reg [AW-1:0] ea_o,
    output reg ea_valid_o,
    output reg [AW-1:0] ptr_wb_o,
    output reg ptr_wb_en_o,
    output reg [3:0] ptr_wb_sel_o,
    output reg [3:0] default_default_working_register_o,
    output reg [AW-1:0] operand_lit_o,
    output reg [AW-1:0] push_word_o,
    output wire overflow_trap_o,
    output wire underflow_trap_o,
    output wire [AW-1:0] stack_limit_o,
    output reg limit_hazard_o,
    output wire [AW-1:0] branch_offset_o,
    output wire [AW-1:0] disable_interrupts_instr_count_o
);

    // -----------------------------------------------------------------
    // Local state and helpers
    // -----------------------------------------------------------------
    reg [AW-1:0] stack_limit;
    reg [AW-1:0] next_ea;
    reg [AW-1:0] next_wb;
    reg next_wb_en;
    reg [AW-1:0] next_lit;
    reg [AW-1:0] next_push;
    reg uses_sp;
    wire chk_over;
    wire chk_under;

    // Sign extend a literal of given width
    function [AW-1:0] slag_sext;
        input [AW-1:0] v;
        input [4:0] w;
        integer k;
        begin
            slag_sext = v;
            for (k = 0; k < AW; k = k + 1)
            begin
                if (k >= w)
                begin
                    slag_sext[k] = v[w-1];
                end
            end
        end
    endfunction

    // Zero extend a literal of given width
    function [AW-1:0] slag_zext;
        input [AW-1:0] v;
        input [4:0] w;
        integer k;
        begin
            slag_zext = v;
            for (k = 0; k < AW; k = k + 1)
            begin
                if (k >= w)
                begin
                    slag_zext[k] = 1'b0;
                end
            end
        end
    endfunction

    // -----------------------------------------------------------------
    // Stack limit register
    // -----------------------------------------------------------------
    // No reset: value is undefined until software writes it
    always @(posedge clock_i)
    begin
        if (limit_wr_i)
        begin
            stack_limit <= {limit_data_i[AW-1:1], 1'b0};
        end
    end

    assign stack_limit_o = {stack_limit[AW-1:1], 1'b0};

    // Flag the cycle after a limit write, whether or not a stack access follows
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            limit_hazard_o <= 1'b0;
        end
        else
        begin
            limit_hazard_o <= limit_wr_i;
        end
    end

    // -----------------------------------------------------------------
    // Effective address generation
    // -----------------------------------------------------------------
    always @*
    begin
        next_ea = {AW{1'b0}};
        next_wb = ptr_val_i;
        next_wb_en = 1'b0;
        next_lit = {AW{1'b0}};
        next_push = {AW{1'b0}};
        uses_sp = (ptr_sel_i == `SLAG_SP_INDEX);
        // Literal width selection
        case (lit_width_i)
            2'h0: next_lit = slag_zext(literal_i, `SLAG_LIT5_WIDTH);
            2'h1: next_lit = slag_zext(literal_i, `SLAG_LIT10_WIDTH);
            2'h2: next_lit = slag_zext(literal_i, `SLAG_LIT8_WIDTH);
            default: next_lit = literal_i;
        endcase
        if (stack_op_i == `SLAG_STK_PUSH || stack_op_i == `SLAG_STK_PCPUSH)
        begin
            // Write at free word, then step up
            uses_sp = 1'b1;
            next_ea = ptr_val_i;
            next_wb = ptr_val_i + `SLAG_WORD_STEP;
            next_wb_en = 1'b1;
            if (exception_i)
            begin
                next_push = {{(AW-15){1'b0}}, status_low_i, pc_high_i};
            end
            else
            begin
                next_push = {{(AW-7){1'b0}}, pc_high_i};
            end
        end
        else if (stack_op_i == `SLAG_STK_POP)
        begin
            // Step down first, read from the new top
            uses_sp = 1'b1;
            next_ea = ptr_val_i - `SLAG_WORD_STEP;
            next_wb = next_ea;
            next_wb_en = 1'b1;
        end
        else
        begin
            case (mode_i)
                `SLAG_MODE_FILE: next_ea = {{(AW-`SLAG_NEAR_WIDTH){1'b0}}, file_addr_i};
                `SLAG_MODE_INDIRECT: next_ea = ptr_val_i;
                `SLAG_MODE_POST:
                begin
                    next_ea = ptr_val_i;
                    next_wb = step_down_i ? ptr_val_i - step_i : ptr_val_i + step_i;
                    next_wb_en = 1'b1;
                end
                `SLAG_MODE_PRE:
                begin
                    next_wb = ptr_val_i + slag_sext(step_i, `SLAG_LIT16_WIDTH);
                    next_ea = next_wb;
                    next_wb_en = 1'b1;
                end
                `SLAG_MODE_INDEXED: next_ea = ptr_val_i + base_val_i;
                `SLAG_MODE_LITOFF: next_ea = ptr_val_i + next_lit;
                default: next_ea = {AW{1'b0}};
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Limit and floor check on stack pointer addresses
    // -----------------------------------------------------------------
    slag_limit_check #(.AW(AW)) u_check
    (
        .addr_i(next_ea),
        .limit_i(stack_limit_o),
        .check_i(req_i && uses_sp && (mode_i != `SLAG_MODE_FILE) &&
                 (mode_i != `SLAG_MODE_DIRECT) && (mode_i != `SLAG_MODE_LITERAL)),
        .over_o(chk_over),
        .under_o(chk_under)
    );

    // Trap requests are combinational and leave one cycle ahead of the registered ea_o
    assign overflow_trap_o = chk_over;
    assign underflow_trap_o = chk_under;

    // -----------------------------------------------------------------
    // Registered outputs to the data memory and register file
    // -----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ea_o <= {AW{1'b0}};
            ea_valid_o <= 1'b0;
            ptr_wb_o <= {AW{1'b0}};
            ptr_wb_en_o <= 1'b0;
            ptr_wb_sel_o <= 4'h0;
            default_default_working_register_o <= 4'h0;
            operand_lit_o <= {AW{1'b0}};
            push_word_o <= {AW{1'b0}};
        end
        else
        begin
            ea_o <= next_ea;
            ea_valid_o <= req_i && (mode_i != `SLAG_MODE_DIRECT) && (mode_i != `SLAG_MODE_LITERAL);
            ptr_wb_o <= next_wb;
            ptr_wb_en_o <= req_i && next_wb_en;
            ptr_wb_sel_o <= (stack_op_i != `SLAG_STK_NONE) ? `SLAG_SP_INDEX : ptr_sel_i;
            default_default_working_register_o <= (mode_i == `SLAG_MODE_FILE) ? `SLAG_DEFAULT_WORKING_REGISTER_INDEX : offset_sel_i;
            operand_lit_o <= next_lit;
            push_word_o <= next_push;
        end
    end

    // Branch and interrupt-disable literal fields
    assign branch_offset_o = slag_sext(literal_i, `SLAG_BRA_WIDTH);
    assign disable_interrupts_instr_count_o = slag_zext(literal_i, `SLAG_DISABLE_INTERRUPTS_INSTR_WIDTH);

endmodule
`default_nettype wire

/* dv/slag_core_props.sv */
// Concurrent checks on the ports of the address generation core.
// Assumes one clock domain and the limit written before stack pushes.
`timescale 1ns/1ps
`default_nettype none
`include "slag_map.vh"
module slag_core_props
#(
    parameter AW = 16
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic [7:0] mode_i,
    input wire logic [3:0] ptr_sel_i,
    input wire logic [AW-1:0] ptr_val_i,
    input wire logic [AW-1:0] base_val_i,
    input wire logic [12:0] file_addr_i,
    input wire logic [3:0] stack_op_i,
    input wire logic [AW-1:0] literal_i,
    input wire logic limit_wr_i,
    input wire logic [AW-1:0] limit_data_i,
    input wire logic [AW-1:0] ea_o,
    input wire logic [AW-1:0] ptr_wb_o,
    input wire logic [3:0] default_default_working_register_o,
    input wire logic overflow_trap_o,
    input wire logic underflow_trap_o,
    input wire logic [AW-1:0] stack_limit_o,
    input wire logic limit_hazard_o,
    input wire logic [AW-1:0] disable_interrupts_instr_count_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic lim_ok;
    logic push_sp;
    // Limit is trusted only once it has been written
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i) lim_ok <= 1'b0;
        else if (limit_wr_i) lim_ok <= 1'b1;
    end
    assign push_sp = req_i && ptr_sel_i == 4'hf && stack_op_i == `SLAG_STK_PUSH && lim_ok;
    lim_bit0_a: assert property (stack_limit_o[0] == 1'b0) else $error("limit bit0 set");
    lim_load_a: assert property (limit_wr_i |=>
        stack_limit_o[15:1] == $past(limit_data_i[15:1])) else $error("limit not loaded");
    push_step_a: assert property (req_i && stack_op_i == `SLAG_STK_PUSH |=>
        ea_o == $past(ptr_val_i) && ptr_wb_o == $past(ptr_val_i) + 16'h0002)
        else $error("push address wrong");
    pop_step_a: assert property (req_i && stack_op_i == `SLAG_STK_POP |=>
        ea_o == $past(ptr_val_i) - 16'h0002 && ptr_wb_o == ea_o) else $error("pop wrong");
    over_trap_a: assert property (push_sp |->
        overflow_trap_o == (ptr_val_i > stack_limit_o)) else $error("overflow trap wrong");
    under_trap_a: assert property (push_sp |->
        underflow_trap_o == (ptr_val_i < 16'h0800)) else $error("underflow trap wrong");
    file_addr_a: assert property (req_i && mode_i == `SLAG_MODE_FILE |=>
        default_default_working_register_o == 4'h0 && ea_o == {3'h0, $past(file_addr_i)})
        else $error("file address wrong");
    index_sum_a: assert property (req_i && mode_i == `SLAG_MODE_INDEXED |=>
        ea_o == $past(ptr_val_i) + $past(base_val_i)) else $error("indexed wrong");
    limit_hazard_a: assert property (limit_wr_i |=>
        limit_hazard_o ##1 !limit_hazard_o) else $error("hazard flag wrong");
    disable_interrupts_instr_field_a: assert property (disable_interrupts_instr_count_o == {2'h0, literal_i[13:0]})
        else $error("disable_interrupts_instr field wrong");
endmodule
bind slag_core slag_core_props #(.AW(AW)) u_props (.*);
`default_nettype wire

/* dv/slag_dmem_model.sv */
// Data memory stand-in: latches each effective address it is handed.
// Assumes the core presents ea_o with ea_valid_o for one cycle.
`timescale 1ns/1ps
`default_nettype none
module slag_dmem_model
(
    input wire logic clock_i,
    input wire logic [15:0] ea_i,
    input wire logic ea_valid_i,
    output logic [15:0] last_ea_o
);
    // Capture address on each valid access
    always @(posedge clock_i)
    begin
        if (ea_valid_i) last_ea_o <= ea_i;
    end
endmodule
`default_nettype wire

/* dv/tb_slag_core.sv */
// Self-checking bench for the address generation and stack check core.
// Assumes inputs change on the falling edge and outputs settle by then.
`timescale 1ns/1ps
`default_nettype none
`include "slag_map.vh"
module tb_slag_core;
    logic clock_i = 0, rst_n_i = 0, req_i = 0, step_down_i = 0, exception_i = 0, limit_wr_i = 0;
    logic [7:0] mode_i = 0, status_low_i = 8'ha5;
    logic [3:0] ptr_sel_i = 0, offset_sel_i = 4'h5, stack_op_i = 4'h1;
    logic [15:0] ptr_val_i = 0, base_val_i = 0, literal_i = 0, step_i = 0, limit_data_i = 0;
    logic [1:0] lit_width_i = 0;
    logic [12:0] file_addr_i = 13'h1abc;
    logic [6:0] pc_high_i = 7'h55;
    logic [15:0] ea_o, ptr_wb_o, operand_lit_o, push_word_o, stack_limit_o, branch_offset_o;
    logic [15:0] disable_interrupts_instr_count_o, last_ea;
    logic [3:0] ptr_wb_sel_o, default_default_working_register_o;
    logic ea_valid_o, ptr_wb_en_o, overflow_trap_o, underflow_trap_o, limit_hazard_o, ov, un;
    integer bad_count = 0, n_checks = 0, w;
    slag_core dut (.*);
    slag_dmem_model u_mem (.clock_i(clock_i), .ea_i(ea_o), .ea_valid_i(ea_valid_o),
        .last_ea_o(last_ea));
    initial forever #10 clock_i = ~clock_i;
    task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wrap_up;
    begin
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    end
    endtask
    // One request cycle; traps sampled 1 ns after the inputs change, registered results at next fall
    task go(input logic [7:0] m, input logic [3:0] s, input logic [15:0] p, input logic [15:0] a,
        input logic [3:0] op);
    begin
        @(negedge clock_i);
        mode_i = m; ptr_sel_i = s; ptr_val_i = p; base_val_i = a; literal_i = a; step_i = a;
        stack_op_i = op; req_i = 1;
        #1 ov = overflow_trap_o; un = underflow_trap_o;
        @(negedge clock_i);
        req_i = 0;
    end
    endtask
    task t_limit;
    begin
        @(negedge clock_i); limit_wr_i = 1; limit_data_i = 16'h0fff;
        @(negedge clock_i); limit_wr_i = 0;
        chk(stack_limit_o, 16'h0ffe);
        chk({15'h0, limit_hazard_o}, 16'h0001);
        @(negedge clock_i);
    end
    endtask
    task t_push;
    begin
        go(`SLAG_MODE_INDIRECT, 4'hf, 16'h0ffe, 16'h0002, `SLAG_STK_PUSH);
        chk({15'h0, ov}, 16'h0000);
        chk(ea_o, 16'h0ffe);
        chk(ptr_wb_o, 16'h1000);
        chk({11'h0, ptr_wb_en_o, ptr_wb_sel_o}, 16'h001f);
        go(`SLAG_MODE_INDIRECT, 4'hf, 16'h1000, 16'h0002, `SLAG_STK_PUSH);
        chk({15'h0, ov}, 16'h0001);
        chk(last_ea, 16'h0ffe);
        go(`SLAG_MODE_INDIRECT, 4'hf, 16'h07fe, 16'h0002, `SLAG_STK_PUSH);
        chk({14'h0, ov, un}, 16'h0001);
        step_down_i = 1;
        go(`SLAG_MODE_PRE, 4'hf, 16'h0900, 16'hfffe, `SLAG_STK_POP);
        chk(ea_o, 16'h08fe);
        chk({15'h0, un}, 16'h0000);
    end
    endtask
    task t_modes;
    begin
        go(`SLAG_MODE_POST, 4'h3, 16'h1234, 16'h0002, `SLAG_STK_NONE);
        chk(ptr_wb_o, 16'h1232);
        step_down_i = 0;
        go(`SLAG_MODE_POST, 4'h3, 16'h1234, 16'h0002, `SLAG_STK_NONE);
        chk(ea_o, 16'h1234);
        chk(ptr_wb_o, 16'h1236);
        go(`SLAG_MODE_PRE, 4'h3, 16'h1234, 16'hfffc, `SLAG_STK_NONE);
        chk(ea_o, 16'h1230);
        go(`SLAG_MODE_INDEXED, 4'h3, 16'h1000, 16'h0246, `SLAG_STK_NONE);
        chk(ea_o, 16'h1246);
        chk({12'h0, default_default_working_register_o}, 16'h0005);
        go(`SLAG_MODE_LITOFF, 4'h3, 16'h1000, 16'h0010, `SLAG_STK_NONE);
        chk(ea_o, 16'h1010);
        go(`SLAG_MODE_INDIRECT, 4'hf, 16'h1002, 16'h0000, `SLAG_STK_NONE);
        chk({14'h0, ov, un}, 16'h0002);
        go(`SLAG_MODE_DIRECT, 4'hf, 16'h0700, 16'h0000, `SLAG_STK_NONE);
        chk({14'h0, ea_valid_o, un}, 16'h0000);
        go(`SLAG_MODE_FILE, 4'h3, 16'h1000, 16'h0010, `SLAG_STK_NONE);
        chk(ea_o, 16'h1abc);
        chk({15'h0, ea_valid_o}, 16'h0001);
        chk({12'h0, default_default_working_register_o}, 16'h0000);
    end
    endtask
    task t_lits;
        logic [15:0] exp [0:3];
    begin
        exp[0] = 16'h000f; exp[1] = 16'h02ef; exp[2] = 16'h00ef; exp[3] = 16'hbeef;
        for (w = 0; w < 4; w = w + 1)
        begin
            lit_width_i = w[1:0];
            go(`SLAG_MODE_LITERAL, 4'h1, 16'h0000, 16'hbeef, `SLAG_STK_NONE);
            chk(operand_lit_o, exp[w]);
        end
        chk(disable_interrupts_instr_count_o, 16'h3eef);
        chk(branch_offset_o, 16'hbeef);
    end
    endtask
    task t_pcpush;
    begin
        go(`SLAG_MODE_INDIRECT, 4'hf, 16'h0900, 16'h0002, `SLAG_STK_PCPUSH);
        chk(push_word_o, 16'h0055);
        exception_i = 1;
        go(`SLAG_MODE_INDIRECT, 4'hf, 16'h0900, 16'h0002, `SLAG_STK_PCPUSH);
        chk(push_word_o, 16'h52d5);
    end
    endtask
    // Main sequence after a 20 cycle reset
    initial
    begin
        repeat (20) @(negedge clock_i);
        rst_n_i = 1;
        t_limit;
        t_push;
        t_modes;
        t_lits;
        t_pcpush;
        wrap_up;
    end
    // Watchdog against a hang
    initial
    begin
        #100000;
        bad_count = bad_count + 1;
        wrap_up;
    end
endmodule
`default_nettype wire
